// >>> shared/mpc_pkg.sv
package mpc_pkg;
  // system clock rate
  localparam int unsigned CLK_HZ = 50_000_000;
  // minimum output hold after a zero or compare hit, in ms
  localparam int unsigned HOLD_TIME_MS = 100;
  localparam logic [7:0] HOLD_MS_COUNT = 8'(HOLD_TIME_MS);
  // hold prescaler: one tick per millisecond
  localparam int unsigned MS_HZ = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_HZ;
  // reference ticks for pulse-width modes
  localparam int unsigned FREF_FIXED_HZ = 50_000;
  localparam int unsigned FREF_10M_HZ = 10_000_000;
  localparam int unsigned FREF_1M_HZ = 1_000_000;
  localparam int unsigned FREF_100K_HZ = 100_000;
  localparam int unsigned FREF_10K_HZ = 10_000;
  localparam logic [15:0] FIXED_CYC = 16'(CLK_HZ / FREF_FIXED_HZ);
  localparam logic [15:0] REF_10M_CYC = 16'(CLK_HZ / FREF_10M_HZ);
  localparam logic [15:0] REF_1M_CYC = 16'(CLK_HZ / FREF_1M_HZ);
  localparam logic [15:0] REF_100K_CYC = 16'(CLK_HZ / FREF_100K_HZ);
  localparam int unsigned REF_10K_CYC = CLK_HZ / FREF_10K_HZ;
  // reference tick selector codes
  localparam logic [1:0] FREF_SEL_10M = 2'h0;
  localparam logic [1:0] FREF_SEL_1M = 2'h1;
  localparam logic [1:0] FREF_SEL_100K = 2'h2;
  // counting modes
  localparam logic [4:0] MODE_UPDOWN32 = 5'h00;
  localparam logic [4:0] MODE_ENC1 = 5'h01;
  localparam logic [4:0] MODE_PULSE_FIXED = 5'h06;
  localparam logic [4:0] MODE_GATE_UP = 5'h0c;
  localparam logic [4:0] MODE_GATE_DN = 5'h0d;
  localparam logic [4:0] MODE_RLD_UP = 5'h0e;
  localparam logic [4:0] MODE_RLD_DN = 5'h0f;
  localparam logic [4:0] MODE_FREQ_GATE = 5'h12;
  localparam logic [4:0] MODE_PERIOD_GATE = 5'h13;
  localparam logic [4:0] MODE_PULSE_LOW_DIR = 5'h14;
  localparam logic [4:0] MODE_PULSE_LOW_GATE = 5'h15;
  localparam logic [4:0] MODE_PULSE_HIGH_GATE = 5'h16;
  localparam logic [4:0] MODE_LAST = 5'h1a;
  // highest plain mode per hardware revision
  localparam logic [3:0] REV_BASE = 4'h3;
  localparam logic [3:0] REV_EXT = 4'h4;
  localparam logic [3:0] REV_MEAS = 4'h5;
  localparam logic [3:0] REV_PULSE = 4'h6;
  localparam logic [4:0] LAST_BASE = 5'h05;
  localparam logic [4:0] LAST_EXT = 5'h11;
  localparam logic [4:0] LAST_MEAS = 5'h13;
  localparam logic [4:0] FIRST_PW = 5'h14;
  // register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_COMPARE = 5'h04;
  localparam logic [4:0] REG_RELOAD = 5'h08;
  localparam logic [4:0] REG_COUNT = 5'h0c;
  localparam logic [4:0] REG_RESULT = 5'h10;
  localparam logic [4:0] REG_STATUS = 5'h14;
  localparam logic [4:0] REG_VERSION = 5'h18;
  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_FREF_LSB = 8;
  localparam int ST_OUT = 0;
  localparam int ST_MGATE = 1;
  localparam int ST_NEW = 2;
  localparam int ST_MEAS = 3;
  localparam int ST_MODE_OK = 4;
  localparam int ST_RUN = 5;
  // field inputs, carried together
  typedef struct packed {
    logic clear;
    logic stop;
    logic start;
    logic gate;
    logic dir_b;
    logic clk_a;
  } field_s;
  // pulse-width measurement states
  typedef enum logic {PW_IDLE, PW_MEASURE} pw_state_e;
endpackage : mpc_pkg

// >>> sim/field_model.sv
`timescale 1ns/1ps
module field_model (
  // clock that paces the pin changes
  input wire logic clk_sys,
  // pins toward the counter channel
  output mpc_pkg::field_s pins
);
  import mpc_pkg::*;
  // all pins idle low, clear low so that counting may run
  initial begin
    pins = '0;
  end
  // let some system clocks pass
  task automatic hold_for(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : hold_for
  // drive one pin level; slow enough that the synchroniser never misses it
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk_sys);
    pins[idx] <= v;
    hold_for(6);
  endtask : set_pin
  // n edges on the count clock, alternating rise and fall
  task automatic toggle(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      pins.clk_a <= ~pins.clk_a;
      hold_for(5);
    end
  endtask : toggle
  // one pulse of level lvl, n+1 cycles wide, then back to idle
  task automatic pulse(input logic lvl, input int n);
    @(posedge clk_sys);
    pins.clk_a <= lvl;
    hold_for(n);
    @(posedge clk_sys);
    pins.clk_a <= ~lvl;
    hold_for(10);
  endtask : pulse
endmodule : field_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import mpc_pkg::*;
  // shortened prescale: 100 ms becomes 1000 cycles
  localparam int HOLD_CYC = 1000;
  // bus side
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [3:0] lanes = 4'hf; // byte lanes the next transfer will carry
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // field side
  field_s field_in;
  logic count_out_active;
  logic meas_gate_out;
  // last read word and bookkeeping
  logic [31:0] q;
  int errors = 0;
  int checked = 0;
  // tick period per selector; the 10 kHz one is shortened
  int ref_cyc [4] = '{5, 50, 500, 20};
  // only codes above the last pulse mode are missing at this revision
  logic [4:0] mode_tab [4] = '{5'h00, 5'h03, 5'h18, 5'h1b};
  logic mode_ok [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  multimode_pulse_counter #(
    .MS_CYCLES_P(16'h000a),
    .REF_10K_CYCLES_P(16'h0014)
  ) dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .field_in(field_in),
    .count_out_active(count_out_active),
    .meas_gate_out(meas_gate_out)
  );

  field_model field_u (
    .clk_sys(clk_sys),
    .pins(field_in)
  );

  // verdict and end of run
  task automatic wrap_up;
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // exact value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // measured width compare; the tick phase makes it one count loose
  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checked++;
    if ($isunknown(got) || got < lo || got > hi) begin
      errors++;
      $display("wrong value at %0t: got %h range %h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng
  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= lanes;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      errors++;
      $display("wrong value at %0t: bus never answered", $time);
      wrap_up();
    end
  endtask : bus
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  // mode and tick selector in the control word
  task automatic set_mode(input logic [4:0] m, input logic [1:0] sel);
    wr(REG_CTRL, {22'h0, sel, 3'h0, m});
  endtask : set_mode
  // outputs sampled at an edge, where they are settled
  task automatic out_is(input logic exp);
    @(posedge clk_sys);
    chk(32'(count_out_active), 32'(exp));
  endtask : out_is
  task automatic gate_is(input logic exp);
    @(posedge clk_sys);
    chk(32'(meas_gate_out), 32'(exp));
  endtask : gate_is
  // short clear pulse; pin indices: 5 clear, 4 stop, 3 start, 2 gate, 1 dir, 0 clock
  task automatic clear_pulse;
    field_u.set_pin(5, 1'b1);
    field_u.set_pin(5, 1'b0);
  endtask : clear_pulse

  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    field_u.hold_for(2);
    rd(REG_VERSION, 32'h7);
    rd(5'h1c, 32'h0);
    // byte lanes: only the enabled bytes of a write land
    lanes = 4'h5;
    wr(REG_COMPARE, 32'h11223344);
    lanes = 4'h2;
    wr(REG_CTRL, 32'h0000031f);
    lanes = 4'hf;
    rd(REG_COMPARE, 32'h00220044);
    rd(REG_CTRL, 32'h00000300);
    set_mode(MODE_UPDOWN32, 2'h0);
    rd(REG_COUNT, 32'h0);
    out_is(1'b1);
    // mode 0: both edges count, up then down across the half boundary
    field_u.toggle(4);
    rd(REG_COUNT, 32'h4);
    out_is(1'b1);
    field_u.hold_for(HOLD_CYC + 100);
    out_is(1'b0);
    field_u.set_pin(1, 1'b1);
    field_u.toggle(6);
    rd(REG_COUNT, 32'hfffffffe);
    out_is(1'b1);
    // clear held high keeps the count at zero even with edges arriving
    field_u.set_pin(5, 1'b1);
    field_u.toggle(2);
    rd(REG_COUNT, 32'h0);
    field_u.set_pin(5, 1'b0);
    // supported modes at this revision
    for (int i = 0; i < 4; i++) begin
      set_mode(mode_tab[i], 2'h0);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(32'(q[ST_MODE_OK]), 32'(mode_ok[i]));
    end
    // mode 1 encoder: A high first, then clear, then steps with B high
    set_mode(MODE_ENC1, 2'h0);
    field_u.set_pin(1, 1'b0);
    field_u.toggle(1);
    clear_pulse();
    field_u.set_pin(1, 1'b1);
    field_u.toggle(1);
    rd(REG_COUNT, 32'h1);
    field_u.toggle(1);
    rd(REG_COUNT, 32'h0);
    // mode 12: gate low blocks, compare hit drives the output
    wr(REG_COMPARE, 32'h2);
    set_mode(MODE_GATE_UP, 2'h0);
    field_u.toggle(2);
    rd(REG_COUNT, 32'h0);
    field_u.set_pin(2, 1'b1);
    field_u.toggle(2);
    rd(REG_COUNT, 32'h1);
    field_u.hold_for(HOLD_CYC + 100);
    out_is(1'b0);
    field_u.toggle(2);
    rd(REG_COUNT, 32'h2);
    out_is(1'b1);
    // mode 14: landing on compare loads the reload value
    clear_pulse();
    wr(REG_COMPARE, 32'h3);
    wr(REG_RELOAD, 32'h10);
    set_mode(MODE_RLD_UP, 2'h0);
    field_u.toggle(6);
    rd(REG_COUNT, 32'h10);
    out_is(1'b1);
    // mode 18: gate status opens at the first counted rise, closes after stop
    clear_pulse();
    set_mode(MODE_FREQ_GATE, 2'h0);
    field_u.set_pin(3, 1'b1);
    gate_is(1'b0);
    field_u.toggle(2);
    gate_is(1'b1);
    field_u.set_pin(3, 1'b0);
    field_u.set_pin(4, 1'b1);
    field_u.toggle(2);
    gate_is(1'b0);
    field_u.set_pin(4, 1'b0);
    // mode 6: 3.5 fixed ticks low, down then up
    set_mode(MODE_PULSE_FIXED, 2'h0);
    field_u.pulse(1'b0, 3499);
    bus(1'b0, REG_RESULT, 32'h0);
    chk_rng(q, 32'hfffffffc, 32'hfffffffd);
    field_u.set_pin(1, 1'b0);
    field_u.pulse(1'b0, 3499);
    bus(1'b0, REG_RESULT, 32'h0);
    chk_rng(q, 32'h3, 32'h4);
    // mode 20: down once, then every tick selector up
    set_mode(MODE_PULSE_LOW_DIR, 2'h0);
    field_u.set_pin(1, 1'b1);
    field_u.pulse(1'b0, 21);
    bus(1'b0, REG_RESULT, 32'h0);
    chk_rng(q, 32'hfffffffb, 32'hfffffffc);
    field_u.set_pin(1, 1'b0);
    for (int s = 0; s < 4; s++) begin
      set_mode(MODE_PULSE_LOW_DIR, 2'(s));
      field_u.pulse(1'b0, ref_cyc[s] * 9 / 2 - 1);
      bus(1'b0, REG_RESULT, 32'h0);
      chk_rng(q, 32'h4, 32'h5);
    end
    // modes 21 and 22: up count only while gate is high
    set_mode(MODE_PULSE_LOW_GATE, 2'h1);
    field_u.pulse(1'b0, 224);
    bus(1'b0, REG_RESULT, 32'h0);
    chk_rng(q, 32'h4, 32'h5);
    field_u.set_pin(2, 1'b0);
    field_u.pulse(1'b0, 224);
    rd(REG_RESULT, 32'h0);
    field_u.set_pin(2, 1'b1);
    field_u.set_pin(5, 1'b1);
    field_u.set_pin(0, 1'b0);
    set_mode(MODE_PULSE_HIGH_GATE, 2'h1);
    field_u.set_pin(5, 1'b0);
    field_u.pulse(1'b1, 224);
    bus(1'b0, REG_RESULT, 32'h0);
    chk_rng(q, 32'h4, 32'h5);
    wrap_up();
  end
endmodule : testbench

// >>> src/multimode_pulse_counter.sv
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module multimode_pulse_counter #(
  parameter logic [3:0] REVISION = 4'h7,
  parameter logic [15:0] MS_CYCLES_P = 16'(mpc_pkg::MS_CYCLES),
  parameter logic [15:0] REF_10K_CYCLES_P = 16'(mpc_pkg::REF_10K_CYC)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // field side
  input wire mpc_pkg::field_s field_in,
  output logic count_out_active,
  output logic meas_gate_out
);
  import mpc_pkg::*;

  // true when the revision offers the mode
  function automatic logic mode_allowed(logic [4:0] m, logic [3:0] rev);
    mode_allowed = (m <= LAST_BASE && rev >= REV_BASE) || (m <= LAST_EXT && rev >= REV_EXT) ||
                   (m <= LAST_MEAS && rev >= REV_MEAS) ||
                   ((m == MODE_PULSE_FIXED || (m >= FIRST_PW && m <= MODE_LAST)) && rev >= REV_PULSE);
  endfunction : mode_allowed

  // merge a bus write into a register by byte lanes
  function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    be_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) be_merge[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction : be_merge

  // one step of the chained counter: low half ripples its carry or borrow into the high half
  function automatic logic [31:0] chain_step(logic [31:0] v, logic down);
    logic [16:0] lo;
    logic [15:0] hi;
    lo = down ? {1'b0, v[15:0]} - 17'h1 : {1'b0, v[15:0]} + 17'h1;
    hi = down ? v[31:16] - {15'h0, lo[16]} : v[31:16] + {15'h0, lo[16]};
    chain_step = {hi, lo[15:0]};
  endfunction : chain_step

  // synchroniser stages; sync_a is read only by sync_b
  field_s sync_a;
  field_s sync_b;
  field_s prev; // last synchronised sample, for edges

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      prev <= '0;
    end else begin
      sync_a <= field_in;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  logic a_rise; // input a rising
  logic a_fall; // input a falling
  logic clr; // clear level
  assign a_rise = sync_b.clk_a & ~prev.clk_a;
  assign a_fall = ~sync_b.clk_a & prev.clk_a;
  assign clr = sync_b.clear;

  // control registers
  logic [4:0] mode;
  logic [1:0] fref_sel;
  logic [31:0] compare;
  logic [31:0] reload;
  logic [4:0] next_mode;
  logic [1:0] next_fref_sel;
  logic [31:0] next_compare;
  logic [31:0] next_reload;
  // bus state
  logic [31:0] next_readdata;
  logic next_waitrequest;
  // counting state
  logic [31:0] count;
  logic [31:0] result; // last pulse width
  logic result_new; // sticky: a result arrived since last read
  logic run; // start/stop latch
  logic reload_hit; // auto-reload happened last cycle
  pw_state_e pw_state;
  logic [31:0] next_count;
  logic [31:0] next_result;
  logic next_result_new;
  logic next_run;
  logic next_meas_gate;
  logic next_reload_hit;
  pw_state_e next_pw_state;
  // hold timer
  logic [7:0] hold_left; // milliseconds still to hold
  logic [7:0] next_hold_left;
  logic next_out_active;

  logic mode_ok; // mode present in this revision
  logic wr_go; // write accepted this edge
  logic rd_latch; // read data latched this edge
  logic [4:0] word_addr; // aligned byte address
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic pulse_mode;
  logic pw_start; // edge opening a pulse
  logic pw_end; // edge closing a pulse
  logic ref_tick;
  logic ms_tick;
  logic hold_trigger;
  logic [15:0] ref_period;
  logic [31:0] ctrl_merged; // control word with the write's byte lanes applied

  assign mode_ok = mode_allowed(mode, REVISION);
  assign word_addr = {avs_address[4:2], 2'b00};
  assign wr_go = avs_write & ~avs_waitrequest;
  assign rd_latch = avs_read & avs_waitrequest;
  assign pulse_mode = mode_ok && (mode == MODE_PULSE_FIXED || mode == MODE_PULSE_LOW_DIR ||
                      mode == MODE_PULSE_LOW_GATE || mode == MODE_PULSE_HIGH_GATE);
  // high pulse opens on rise, all low-pulse modes open on fall
  assign pw_start = (mode == MODE_PULSE_HIGH_GATE) ? a_rise : a_fall;
  assign pw_end = (mode == MODE_PULSE_HIGH_GATE) ? a_fall : a_rise;
  // a function result cannot be part-selected directly, so the merge gets its own net
  assign ctrl_merged = be_merge(ctrl_word, avs_writedata, avs_byteenable);

  // register views for reads and byte-lane writes
  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_MODE_LSB +: 5] = mode;
    ctrl_word[CTRL_FREF_LSB +: 2] = fref_sel;
    status_word = '0;
    status_word[ST_OUT] = count_out_active;
    status_word[ST_MGATE] = meas_gate_out;
    status_word[ST_NEW] = result_new;
    status_word[ST_MEAS] = (pw_state == PW_MEASURE);
    status_word[ST_MODE_OK] = mode_ok;
    status_word[ST_RUN] = run;
  end

  // reference tick period: fixed in mode 6, selectable otherwise
  always_comb begin
    if (mode == MODE_PULSE_FIXED) begin
      ref_period = FIXED_CYC;
    end else begin
      unique case (fref_sel)
        FREF_SEL_10M: ref_period = REF_10M_CYC;
        FREF_SEL_1M: ref_period = REF_1M_CYC;
        FREF_SEL_100K: ref_period = REF_100K_CYC;
        default: ref_period = REF_10K_CYCLES_P;
      endcase
    end
  end

  // reference time base, phase-aligned to the opening edge
  tick_divider u_ref_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(pulse_mode && pw_state == PW_IDLE && pw_start),
    .period(ref_period),
    .tick(ref_tick)
  );

  // millisecond prescaler for the output hold, restarted on every hit
  tick_divider u_ms_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .restart(hold_trigger),
    .period(MS_CYCLES_P),
    .tick(ms_tick)
  );

  // bus slave: one wait state, read data latched while waitrequest is high
  always_comb begin
    next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
    next_readdata = avs_readdata;
    if (rd_latch) begin
      unique case (word_addr)
        REG_CTRL: next_readdata = ctrl_word;
        REG_COMPARE: next_readdata = compare;
        REG_RELOAD: next_readdata = reload;
        REG_COUNT: next_readdata = count;
        REG_RESULT: next_readdata = result;
        REG_STATUS: next_readdata = status_word;
        REG_VERSION: next_readdata = {28'h0, REVISION};
        default: next_readdata = '0; // unmapped reads as zero
      endcase
    end
  end

  // control registers take writes only on the accepting edge
  always_comb begin
    next_mode = mode;
    next_fref_sel = fref_sel;
    next_compare = compare;
    next_reload = reload;
    if (wr_go && word_addr == REG_CTRL) begin
      next_mode = ctrl_merged[CTRL_MODE_LSB +: 5];
      next_fref_sel = ctrl_merged[CTRL_FREF_LSB +: 2];
    end
    if (wr_go && word_addr == REG_COMPARE) next_compare = be_merge(compare, avs_writedata, avs_byteenable);
    if (wr_go && word_addr == REG_RELOAD) next_reload = be_merge(reload, avs_writedata, avs_byteenable);
  end

  // counting core
  always_comb begin
    logic step_up;
    logic step_dn;
    step_up = 1'b0;
    step_dn = 1'b0;
    next_count = count;
    next_result = result;
    next_result_new = result_new;
    next_run = run;
    next_meas_gate = meas_gate_out;
    next_pw_state = pw_state;
    next_reload_hit = 1'b0;
    // reading the result clears the flag; a completion in the same cycle sets it again
    if (rd_latch && word_addr == REG_RESULT) next_result_new = 1'b0;
    if (sync_b.start) next_run = 1'b1;
    if (sync_b.stop) next_run = 1'b0; // stop wins over start
    if (mode_ok) begin
      unique case (mode)
        MODE_UPDOWN32: begin
          if (a_rise | a_fall) begin
            step_dn = sync_b.dir_b;
            step_up = ~sync_b.dir_b;
          end
        end
        MODE_ENC1: begin
          step_up = a_fall & sync_b.dir_b;
          step_dn = a_rise & sync_b.dir_b;
        end
        MODE_GATE_UP, MODE_RLD_UP: step_up = a_rise & sync_b.gate;
        MODE_GATE_DN, MODE_RLD_DN: step_dn = a_rise & sync_b.gate;
        MODE_FREQ_GATE, MODE_PERIOD_GATE: begin
          // status rises on the first counted clock, falls on the first clock after stop
          if (a_rise) begin
            step_up = run;
            next_meas_gate = run;
          end
        end
        MODE_PULSE_FIXED, MODE_PULSE_LOW_DIR, MODE_PULSE_LOW_GATE, MODE_PULSE_HIGH_GATE: begin
          unique case (pw_state)
            PW_IDLE: begin
              if (pw_start) begin
                next_count = '0;
                next_pw_state = PW_MEASURE;
              end
            end
            PW_MEASURE: begin
              if (pw_end) begin
                next_result = count;
                next_result_new = 1'b1;
                next_pw_state = PW_IDLE;
              end else if (ref_tick) begin
                if (mode == MODE_PULSE_FIXED || mode == MODE_PULSE_LOW_DIR) begin
                  step_dn = sync_b.dir_b;
                  step_up = ~sync_b.dir_b;
                end else begin
                  step_up = sync_b.gate;
                end
              end
            end
          endcase
        end
        default: ;
      endcase
    end
    if (step_up | step_dn) next_count = chain_step(count, step_dn);
    // auto-reload: the counter restarts from the reload value at the compare value
    if ((step_up | step_dn) && (mode == MODE_RLD_UP || mode == MODE_RLD_DN) && next_count == compare) begin
      next_count = reload;
      next_reload_hit = 1'b1;
    end
    // clear has the last word; a pulse in progress is abandoned
    if (clr) begin
      next_count = '0;
      next_pw_state = PW_IDLE;
    end
  end

  // a hit restarts the hold; the output stays while the hit condition lasts
  assign hold_trigger = mode_ok && (((mode == MODE_UPDOWN32 || mode == MODE_ENC1) && count == '0) ||
                        ((mode == MODE_GATE_UP || mode == MODE_GATE_DN) && count == compare) ||
                        reload_hit);

  // hold timer in milliseconds
  always_comb begin
    next_hold_left = hold_left;
    if (hold_trigger) begin
      next_hold_left = HOLD_MS_COUNT;
    end else if (ms_tick && hold_left != '0) begin
      next_hold_left = hold_left - 8'h1;
    end
    next_out_active = hold_trigger | (next_hold_left != '0);
  end

  // all state except the synchronisers and the check counter registered here
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mode <= MODE_UPDOWN32;
      fref_sel <= FREF_SEL_10M;
      compare <= '0;
      reload <= '0;
      avs_readdata <= '0;
      avs_waitrequest <= 1'b1;
      count <= '0;
      result <= '0;
      result_new <= 1'b0;
      run <= 1'b0;
      meas_gate_out <= 1'b0;
      reload_hit <= 1'b0;
      pw_state <= PW_IDLE;
      hold_left <= '0;
      count_out_active <= 1'b0;
    end else begin
      mode <= next_mode;
      fref_sel <= next_fref_sel;
      compare <= next_compare;
      reload <= next_reload;
      avs_readdata <= next_readdata;
      avs_waitrequest <= next_waitrequest;
      count <= next_count;
      result <= next_result;
      result_new <= next_result_new;
      run <= next_run;
      meas_gate_out <= next_meas_gate;
      reload_hit <= next_reload_hit;
      pw_state <= next_pw_state;
      hold_left <= next_hold_left;
      count_out_active <= next_out_active;
    end
  end

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // cycles since the last hold trigger, saturating
  logic [31:0] hold_age;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) hold_age <= 32'hffffffff;
    else if (hold_trigger) hold_age <= '0;
    else if (hold_age != 32'hffffffff) hold_age <= hold_age + 32'h1;
  end

  a_clear_wipes: assert property (clr |=> count == '0)
    else $error("clear did not erase the counter");
  a_mode0_up: assert property (mode_ok && mode == MODE_UPDOWN32 && a_fall && !sync_b.dir_b && !clr
    |=> count == $past(count) + 32'h1)
    else $error("mode 0 up step wrong");
  a_enc_inc: assert property (mode_ok && mode == MODE_ENC1 && a_fall && sync_b.dir_b && !clr
    |=> count == $past(count) + 32'h1)
    else $error("encoder increment missing");
  a_enc_dec: assert property (mode_ok && mode == MODE_ENC1 && a_rise && sync_b.dir_b && !clr
    |=> count == $past(count) - 32'h1)
    else $error("encoder decrement missing");
  a_gate_freeze: assert property (mode_ok && mode == MODE_GATE_UP && !sync_b.gate && !clr
    |=> $stable(count))
    else $error("counted with gate low");
  // reload lands first, the held output follows one edge later
  sequence reload_then_out;
    count == $past(reload) ##1 count_out_active;
  endsequence
  a_reload_load: assert property (mode_ok && mode == MODE_RLD_UP && a_rise && sync_b.gate && !clr &&
    chain_step(count, 1'b0) == compare |=> reload_then_out)
    else $error("auto-reload not applied");
  a_hold_min: assert property (hold_age < 32'(HOLD_TIME_MS) * 32'(MS_CYCLES_P) |-> count_out_active)
    else $error("output dropped before hold time");
  a_gate_status: assert property (mode_ok && mode == MODE_FREQ_GATE && a_rise && run && !clr
    |=> meas_gate_out && count == $past(count) + 32'h1)
    else $error("measurement gate not raised");
  a_result_store: assert property (pulse_mode && pw_state == PW_MEASURE && pw_end && !clr
    |=> result == $past(count) && pw_state == PW_IDLE && result_new)
    else $error("pulse result not stored");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered");
endmodule : multimode_pulse_counter

// >>> src/tick_divider.sv
`timescale 1ns/1ps
module tick_divider (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic restart,
  input wire logic [15:0] period,
  // one-cycle tick every period cycles
  output logic tick
);
  logic [15:0] cnt; // cycles since last tick
  logic [15:0] next_cnt;
  logic next_tick;

  // restart realigns the phase so a measurement starts on a full period
  always_comb begin
    next_cnt = cnt + 16'h1;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = '0;
    end else if (cnt >= period - 16'h1) begin
      next_cnt = '0;
      next_tick = 1'b1;
    end
  end

  // register only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule : tick_divider
